// *** hw/tpg_pkg.sv ***
// Package for the two-port GPIO block: widths, register offsets,
// field positions, reset values and the APB slave state encoding.
// Assumes a 32-bit APB with byte addresses in the low 8 bits.
package tpg_pkg;

   // Port widths
   localparam int A_W    = 18;
   localparam int B_W    = 17;
   localparam int ADDR_W = 8;
   localparam int DATA_W = 32;

   // Register byte offsets
   localparam logic [7:0] OFF_A_OUT      = 8'h00;
   localparam logic [7:0] OFF_A_DIR      = 8'h04;
   localparam logic [7:0] OFF_A_SRC      = 8'h08;
   localparam logic [7:0] OFF_B_OUT      = 8'h0C;
   localparam logic [7:0] OFF_B_DIR      = 8'h10;
   localparam logic [7:0] OFF_B_SRC      = 8'h14;
   localparam logic [7:0] OFF_IRQ_ENABLE = 8'h30;
   localparam logic [7:0] OFF_IRQ_MASK   = 8'h34;
   localparam logic [7:0] OFF_IRQ_TYPE   = 8'h38;
   localparam logic [7:0] OFF_IRQ_STATUS = 8'h40;
   localparam logic [7:0] OFF_IRQ_RAW    = 8'h44;
   localparam logic [7:0] OFF_IRQ_CLEAR  = 8'h4C;
   localparam logic [7:0] OFF_A_PINS     = 8'h50;
   localparam logic [7:0] OFF_B_PINS     = 8'h54;

   // Field positions
   localparam int SRC_BIT = 0;

   // Source select encoding
   localparam logic SRC_SOFTWARE = 1'b0;
   localparam logic SRC_HARDWARE = 1'b1;

   // Interrupt type encoding
   localparam logic TYPE_LEVEL = 1'b0;
   localparam logic TYPE_EDGE  = 1'b1;

   // Reset values
   localparam logic [A_W-1:0] RST_A_OUT      = 18'h00000;
   localparam logic [A_W-1:0] RST_A_DIR      = 18'h00000;
   localparam logic           RST_A_SRC      = 1'b0;
   localparam logic [B_W-1:0] RST_B_OUT      = 17'h00000;
   localparam logic [B_W-1:0] RST_B_DIR      = 17'h00000;
   localparam logic           RST_B_SRC      = 1'b0;
   localparam logic [A_W-1:0] RST_IRQ_ENABLE = 18'h00000;
   localparam logic [A_W-1:0] RST_IRQ_MASK   = 18'h00000;
   localparam logic [A_W-1:0] RST_IRQ_TYPE   = 18'h00000;

   // APB slave states, Gray coded
   typedef enum logic [0:0] {
      ST_IDLE = 1'b0,
      ST_ACK  = 1'b1
   } tpg_apb_state_t;

endpackage

// *** hw/tpg_top.sv ***
// Two-port GPIO: 18-bit port A with interrupts, 17-bit port B,
// each selectable between software registers and hardware peripherals.
// Assumes pad inputs and peripheral signals are synchronous to ref_clk.
//
// Summary of operation
// - Output value registers drive port lines
// - Direction bit per line: 0 in, 1 out
// - Source bit 0: software 0, hardware 1
// - Per-bit port A interrupt enable
// - Mask bit 1 blocks interrupt, 0 passes
// - Per-bit type: 0 level, 1 edge
// - Only port A lines raise interrupts
//
// Design decision made here: register access over APB.
`timescale 1ns/100ps

module tpg_top (
   // Clock and reset
   input  wire logic                        ref_clk,
   input  wire logic                        arst_n,
   // APB slave
   input  wire logic                        psel,
   input  wire logic                        penable,
   input  wire logic                        pwrite,
   input  wire logic [tpg_pkg::ADDR_W-1:0]  paddr,
   input  wire logic [tpg_pkg::DATA_W-1:0]  pwdata,
   output logic      [tpg_pkg::DATA_W-1:0]  prdata,
   output logic                             pready,
   output logic                             pslverr,
   // Port A pads
   input  wire logic [tpg_pkg::A_W-1:0]     port_a_in,
   output logic      [tpg_pkg::A_W-1:0]     port_a_out,
   output logic      [tpg_pkg::A_W-1:0]     port_a_oe,
   // Port B pads
   input  wire logic [tpg_pkg::B_W-1:0]     port_b_in,
   output logic      [tpg_pkg::B_W-1:0]     port_b_out,
   output logic      [tpg_pkg::B_W-1:0]     port_b_oe,
   // Port A hardware peripheral side
   input  wire logic [tpg_pkg::A_W-1:0]     hw_a_out,
   input  wire logic [tpg_pkg::A_W-1:0]     hw_a_oe,
   output logic      [tpg_pkg::A_W-1:0]     hw_a_in,
   // Port B hardware peripheral side
   input  wire logic [tpg_pkg::B_W-1:0]     hw_b_out,
   input  wire logic [tpg_pkg::B_W-1:0]     hw_b_oe,
   output logic      [tpg_pkg::B_W-1:0]     hw_b_in,
   // Interrupt request to the interrupt controller
   output logic                             irq
);

   // Software registers
   logic [tpg_pkg::A_W-1:0]  a_out_value;
   logic [tpg_pkg::A_W-1:0]  a_direction;
   logic                     a_source;
   logic [tpg_pkg::B_W-1:0]  b_out_value;
   logic [tpg_pkg::B_W-1:0]  b_direction;
   logic                     b_source;
   logic [tpg_pkg::A_W-1:0]  irq_enable;
   logic [tpg_pkg::A_W-1:0]  irq_mask;
   logic [tpg_pkg::A_W-1:0]  irq_type;
   logic [tpg_pkg::A_W-1:0]  edge_latch;
   tpg_pkg::tpg_apb_state_t  state;

   logic [tpg_pkg::A_W-1:0]  next_a_out_value;
   logic [tpg_pkg::A_W-1:0]  next_a_direction;
   logic                     next_a_source;
   logic [tpg_pkg::B_W-1:0]  next_b_out_value;
   logic [tpg_pkg::B_W-1:0]  next_b_direction;
   logic                     next_b_source;
   logic [tpg_pkg::A_W-1:0]  next_irq_enable;
   logic [tpg_pkg::A_W-1:0]  next_irq_mask;
   logic [tpg_pkg::A_W-1:0]  next_irq_type;
   logic [tpg_pkg::A_W-1:0]  next_edge_latch;
   tpg_pkg::tpg_apb_state_t  next_state;
   logic [tpg_pkg::DATA_W-1:0] next_prdata;
   logic                     next_pready;
   logic                     next_pslverr;

   // Pad and interrupt next values
   logic [tpg_pkg::A_W-1:0]  next_port_a_out;
   logic [tpg_pkg::A_W-1:0]  next_port_a_oe;
   logic [tpg_pkg::B_W-1:0]  next_port_b_out;
   logic [tpg_pkg::B_W-1:0]  next_port_b_oe;
   logic                     next_irq;

   // Interrupt condition terms
   logic [tpg_pkg::A_W-1:0]  rise_a;
   logic [tpg_pkg::A_W-1:0]  clear_a;
   logic [tpg_pkg::A_W-1:0]  raw_a;
   logic [tpg_pkg::A_W-1:0]  status_a;
   logic                     wr_ok;

   // Known register offsets only; everything else answers with an error
   function automatic logic is_mapped(input logic [7:0] addr);
      case (addr)
         tpg_pkg::OFF_A_OUT,      tpg_pkg::OFF_A_DIR,
         tpg_pkg::OFF_A_SRC,      tpg_pkg::OFF_B_OUT,
         tpg_pkg::OFF_B_DIR,      tpg_pkg::OFF_B_SRC,
         tpg_pkg::OFF_IRQ_ENABLE, tpg_pkg::OFF_IRQ_MASK,
         tpg_pkg::OFF_IRQ_TYPE,   tpg_pkg::OFF_IRQ_STATUS,
         tpg_pkg::OFF_IRQ_RAW,    tpg_pkg::OFF_IRQ_CLEAR,
         tpg_pkg::OFF_A_PINS,     tpg_pkg::OFF_B_PINS: begin
            is_mapped = 1'b1;
         end
         default: begin
            is_mapped = 1'b0;
         end
      endcase
   endfunction

   // Zero-extend port A and port B fields; reserved bits read as zero
   function automatic logic [31:0] ext_a(input logic [17:0] v);
      ext_a = {14'h0000, v};
   endfunction

   function automatic logic [31:0] ext_b(input logic [16:0] v);
      ext_b = {15'h0000, v};
   endfunction

   // Interrupt detection, port B never contributes
   always_comb begin
      // Registered pad copy doubles as the edge reference
      rise_a = port_a_in & ~hw_a_in;
      clear_a = '0;
      wr_ok = (state == tpg_pkg::ST_ACK) && psel && penable && pwrite
              && is_mapped(paddr);
      if (wr_ok && (paddr == tpg_pkg::OFF_IRQ_CLEAR)) begin
         clear_a = pwdata[tpg_pkg::A_W-1:0];
      end
      // Edge events win over a clear in the same cycle
      next_edge_latch = (edge_latch & ~clear_a)
                        | (rise_a & irq_type);
      raw_a = (hw_a_in & ~irq_type) | (edge_latch & irq_type);
      status_a = raw_a & irq_enable;
      // Registered request lags the condition by one edge
      next_irq = |(status_a & ~irq_mask);
   end

   // Pad drive: software registers or hardware peripheral
   always_comb begin
      // Hardware mode hands over data and enable together
      if (a_source == tpg_pkg::SRC_HARDWARE) begin
         next_port_a_out = hw_a_out;
         next_port_a_oe  = hw_a_oe;
      end else begin
         next_port_a_out = a_out_value;
         next_port_a_oe  = a_direction;
      end
      if (b_source == tpg_pkg::SRC_HARDWARE) begin
         next_port_b_out = hw_b_out;
         next_port_b_oe  = hw_b_oe;
      end else begin
         next_port_b_out = b_out_value;
         next_port_b_oe  = b_direction;
      end
   end

   // APB slave: one wait state so read data comes from a flop
   always_comb begin
      next_state       = state;
      next_prdata      = prdata;
      next_pready      = 1'b0;
      next_pslverr     = 1'b0;
      next_a_out_value = a_out_value;
      next_a_direction = a_direction;
      next_a_source    = a_source;
      next_b_out_value = b_out_value;
      next_b_direction = b_direction;
      next_b_source    = b_source;
      next_irq_enable  = irq_enable;
      next_irq_mask    = irq_mask;
      next_irq_type    = irq_type;
      case (state)
         tpg_pkg::ST_IDLE: begin
            if (psel && penable) begin
               next_state   = tpg_pkg::ST_ACK;
               next_pready  = 1'b1;
               next_pslverr = ~is_mapped(paddr);
               // Writes and errors leave zero on the read bus
               next_prdata  = '0;
               if (!pwrite) begin
                  case (paddr)
                     tpg_pkg::OFF_A_OUT:
                        next_prdata = ext_a(a_out_value);
                     tpg_pkg::OFF_A_DIR:
                        next_prdata = ext_a(a_direction);
                     tpg_pkg::OFF_A_SRC:
                        next_prdata[tpg_pkg::SRC_BIT] = a_source;
                     tpg_pkg::OFF_B_OUT:
                        next_prdata = ext_b(b_out_value);
                     tpg_pkg::OFF_B_DIR:
                        next_prdata = ext_b(b_direction);
                     tpg_pkg::OFF_B_SRC:
                        next_prdata[tpg_pkg::SRC_BIT] = b_source;
                     tpg_pkg::OFF_IRQ_ENABLE:
                        next_prdata = ext_a(irq_enable);
                     tpg_pkg::OFF_IRQ_MASK:
                        next_prdata = ext_a(irq_mask);
                     tpg_pkg::OFF_IRQ_TYPE:
                        next_prdata = ext_a(irq_type);
                     tpg_pkg::OFF_IRQ_STATUS:
                        next_prdata = ext_a(status_a & ~irq_mask);
                     tpg_pkg::OFF_IRQ_RAW:
                        next_prdata = ext_a(raw_a);
                     tpg_pkg::OFF_A_PINS:
                        next_prdata = ext_a(hw_a_in);
                     tpg_pkg::OFF_B_PINS:
                        next_prdata = ext_b(hw_b_in);
                     default: begin
                        next_prdata = '0;
                     end
                  endcase
               end
            end
         end
         tpg_pkg::ST_ACK: begin
            // Write lands on the edge where pready is seen high
            next_state = tpg_pkg::ST_IDLE;
            if (wr_ok) begin
               case (paddr)
                  tpg_pkg::OFF_A_OUT:
                     next_a_out_value = pwdata[tpg_pkg::A_W-1:0];
                  tpg_pkg::OFF_A_DIR:
                     next_a_direction = pwdata[tpg_pkg::A_W-1:0];
                  tpg_pkg::OFF_A_SRC:
                     next_a_source = pwdata[tpg_pkg::SRC_BIT];
                  tpg_pkg::OFF_B_OUT:
                     next_b_out_value = pwdata[tpg_pkg::B_W-1:0];
                  tpg_pkg::OFF_B_DIR:
                     next_b_direction = pwdata[tpg_pkg::B_W-1:0];
                  tpg_pkg::OFF_B_SRC:
                     next_b_source = pwdata[tpg_pkg::SRC_BIT];
                  tpg_pkg::OFF_IRQ_ENABLE:
                     next_irq_enable = pwdata[tpg_pkg::A_W-1:0];
                  tpg_pkg::OFF_IRQ_MASK:
                     next_irq_mask = pwdata[tpg_pkg::A_W-1:0];
                  tpg_pkg::OFF_IRQ_TYPE:
                     next_irq_type = pwdata[tpg_pkg::A_W-1:0];
                  tpg_pkg::OFF_IRQ_STATUS, tpg_pkg::OFF_IRQ_RAW,
                  tpg_pkg::OFF_IRQ_CLEAR,  tpg_pkg::OFF_A_PINS,
                  tpg_pkg::OFF_B_PINS: begin
                     // Read-only views store nothing; clear acts above
                     next_state = tpg_pkg::ST_IDLE;
                  end
                  default: begin
                     next_state = tpg_pkg::ST_IDLE;
                  end
               endcase
            end
         end
         default: begin
            next_state = tpg_pkg::ST_IDLE;
         end
      endcase
   end

   always_ff @(posedge ref_clk or negedge arst_n) begin
      if (!arst_n) begin
         state       <= tpg_pkg::ST_IDLE;
         prdata      <= '0;
         pready      <= 1'b0;
         pslverr     <= 1'b0;
         a_out_value <= tpg_pkg::RST_A_OUT;
         a_direction <= tpg_pkg::RST_A_DIR;
         a_source    <= tpg_pkg::RST_A_SRC;
         b_out_value <= tpg_pkg::RST_B_OUT;
         b_direction <= tpg_pkg::RST_B_DIR;
         b_source    <= tpg_pkg::RST_B_SRC;
         irq_enable  <= tpg_pkg::RST_IRQ_ENABLE;
         irq_mask    <= tpg_pkg::RST_IRQ_MASK;
         irq_type    <= tpg_pkg::RST_IRQ_TYPE;
         edge_latch  <= '0;
         // Pads start undriven until software or hardware asks
         port_a_out  <= '0;
         port_a_oe   <= '0;
         port_b_out  <= '0;
         port_b_oe   <= '0;
         hw_a_in     <= '0;
         hw_b_in     <= '0;
         irq         <= 1'b0;
      end else begin
         state       <= next_state;
         prdata      <= next_prdata;
         pready      <= next_pready;
         pslverr     <= next_pslverr;
         a_out_value <= next_a_out_value;
         a_direction <= next_a_direction;
         a_source    <= next_a_source;
         b_out_value <= next_b_out_value;
         b_direction <= next_b_direction;
         b_source    <= next_b_source;
         irq_enable  <= next_irq_enable;
         irq_mask    <= next_irq_mask;
         irq_type    <= next_irq_type;
         edge_latch  <= next_edge_latch;
         port_a_out  <= next_port_a_out;
         port_a_oe   <= next_port_a_oe;
         port_b_out  <= next_port_b_out;
         port_b_oe   <= next_port_b_oe;
         hw_a_in     <= port_a_in;
         hw_b_in     <= port_b_in;
         irq         <= next_irq;
      end
   end

endmodule

// *** test/tpg_monitor.sv ***
// Checker for the two-port GPIO block, bound to the ports of tpg_top.
// Assumes one clock domain and an APB slave with one wait state.
`timescale 1ns/100ps
module tpg_monitor (
   // Clock and reset
   input wire logic        ref_clk,
   input wire logic        arst_n,
   // APB
   input wire logic        psel,
   input wire logic        penable,
   input wire logic        pwrite,
   input wire logic        pready,
   input wire logic        pslverr,
   input wire logic [7:0]  paddr,
   input wire logic [31:0] pwdata,
   input wire logic [31:0] prdata,
   // Pads, peripherals and interrupt
   input wire logic [17:0] port_a_in,
   input wire logic [17:0] port_a_out,
   input wire logic [17:0] port_a_oe,
   input wire logic [17:0] hw_a_out,
   input wire logic [17:0] hw_a_oe,
   input wire logic [17:0] hw_a_in,
   input wire logic [16:0] port_b_out,
   input wire logic [16:0] port_b_oe,
   input wire logic [16:0] hw_b_out,
   input wire logic [16:0] hw_b_oe,
   input wire logic        irq
);
   default clocking cb @(posedge ref_clk); endclocking
   default disable iff (!arst_n);
   // Shadow of committed writes by word index; registers are not visible
   logic [31:0] sh [32];
   logic [17:0] exp_a_out, exp_a_oe, pass_a;
   logic [16:0] exp_b_out, exp_b_oe;
   logic        lvl, req;
   always_ff @(posedge ref_clk or negedge arst_n) begin
      if (!arst_n) sh <= '{default: '0};
      else if (psel && penable && pready && pwrite && !pslverr)
         sh[paddr[6:2]] <= pwdata;
   end
   assign exp_a_out = sh[2][0] ? hw_a_out : sh[0][17:0];
   assign exp_a_oe  = sh[2][0] ? hw_a_oe : sh[1][17:0];
   assign exp_b_out = sh[5][0] ? hw_b_out : sh[3][16:0];
   assign exp_b_oe  = sh[5][0] ? hw_b_oe : sh[4][16:0];
   assign pass_a    = sh[12][17:0] & ~sh[13][17:0];
   assign lvl       = sh[14][17:0] == 18'h00000;
   assign req       = |(hw_a_in & pass_a);
   sequence s_setup; psel && !penable; endsequence
   sequence s_access; psel && penable; endsequence
   a_wait_state: assert property (s_setup ##1 s_access |-> !pready ##1 pready)
      else $error("pready not on second access cycle");
   a_ready_pulse: assert property (pready |=> !pready)
      else $error("pready high two cycles running");
   a_rsvd_zero: assert property (
      pready && !pwrite |-> prdata[31:18] == 14'h0000)
      else $error("reserved read bits not zero");
   a_drive_a: assert property (
      port_a_out == $past(exp_a_out) && port_a_oe == $past(exp_a_oe))
      else $error("port A drive differs from its source");
   a_drive_b: assert property (
      port_b_out == $past(exp_b_out) && port_b_oe == $past(exp_b_oe))
      else $error("port B drive differs from its source");
   a_irq_level: assert property (
      $past(lvl) |-> irq == $past(req))
      else $error("irq differs from enabled unmasked levels");
   a_irq_block: assert property (
      $past(pass_a) == 0 |-> !irq)
      else $error("irq with no enabled unmasked bit");
   a_hw_in: assert property (
      $past(arst_n) |-> hw_a_in == $past(port_a_in))
      else $error("peripheral input not one cycle behind pad");
endmodule

bind tpg_top tpg_monitor tpg_monitor_inst (
   .ref_clk, .arst_n, .psel, .penable, .pwrite, .pready, .pslverr, .paddr,
   .pwdata, .prdata, .port_a_in, .port_a_out, .port_a_oe, .hw_a_out,
   .hw_a_oe, .hw_a_in, .port_b_out, .port_b_oe, .hw_b_out, .hw_b_oe, .irq
);

// *** test/tpg_pads.sv ***
// Pad model: a line carries the block's level while its enable is high,
// else the outside level. Assumes the bench drives ext_a and ext_b.
`timescale 1ns/100ps
module tpg_pads (
   // Block side
   input  wire logic [17:0] port_a_out,
   input  wire logic [17:0] port_a_oe,
   input  wire logic [16:0] port_b_out,
   input  wire logic [16:0] port_b_oe,
   // Outside world
   input  wire logic [17:0] ext_a,
   input  wire logic [16:0] ext_b,
   // Pad levels back into the block
   output logic      [17:0] port_a_in,
   output logic      [16:0] port_b_in
);
   // Outside source stands off on every driven line
   assign port_a_in = (port_a_oe & port_a_out)
                    | (~port_a_oe & ext_a);
   assign port_b_in = (port_b_oe & port_b_out)
                    | (~port_b_oe & ext_b);
endmodule

// *** test/tb.sv ***
// Bench for the two-port GPIO block: APB master tasks and pad model.
// Assumes every slave answer comes within a few cycles.
`timescale 1ns/100ps
module tb;
   logic        ref_clk, arst_n, psel, penable, pwrite, pready, pslverr;
   logic        irq, e;
   logic [7:0]  paddr;
   logic [31:0] pwdata, prdata, q;
   logic [17:0] port_a_in, port_a_out, port_a_oe, ext_a;
   logic [17:0] hw_a_out, hw_a_oe, hw_a_in;
   logic [16:0] port_b_in, port_b_out, port_b_oe, ext_b;
   logic [16:0] hw_b_out, hw_b_oe, hw_b_in;
   int          n_errors, samples_checked;
   logic [7:0]  offs [8] = '{tpg_pkg::OFF_A_OUT, tpg_pkg::OFF_A_DIR,
                             tpg_pkg::OFF_A_SRC, tpg_pkg::OFF_B_OUT,
                             tpg_pkg::OFF_B_DIR, tpg_pkg::OFF_B_SRC,
                             tpg_pkg::OFF_IRQ_ENABLE, tpg_pkg::OFF_IRQ_MASK};
   logic [31:0] msk [8] = '{32'h3FFFF, 32'h3FFFF, 32'h1, 32'h1FFFF,
                            32'h1FFFF, 32'h1, 32'h3FFFF, 32'h3FFFF};
   tpg_top tpg_top_inst (
      .ref_clk, .arst_n, .psel, .penable, .pwrite, .paddr, .pwdata,
      .prdata, .pready, .pslverr, .port_a_in, .port_a_out, .port_a_oe,
      .port_b_in, .port_b_out, .port_b_oe, .hw_a_out, .hw_a_oe, .hw_a_in,
      .hw_b_out, .hw_b_oe, .hw_b_in, .irq
   );
   tpg_pads tpg_pads_inst (
      .port_a_out, .port_a_oe, .port_b_out, .port_b_oe, .ext_a, .ext_b,
      .port_a_in, .port_b_in
   );
   initial begin
      ref_clk = 1'b0;
      forever #2 ref_clk = ~ref_clk;
   end
   task automatic print_verdict();
      $display("comparisons %0d mismatches %0d", samples_checked, n_errors);
      if (n_errors == 0 && samples_checked > 0) begin
         $display("No errors found");
      end else begin
         $display("Errors were found");
      end
      $finish;
   endtask
   task automatic chk(input string nm, input logic [31:0] seen, exp);
      samples_checked++;
      if (seen !== exp) begin
         n_errors++;
         $display("[ERR] %s expected %h seen %h", nm, exp, seen);
      end
   endtask
   // Request held until pready is seen high at a rising edge
   task automatic apb(input logic        w,
                      input logic [7:0]  a,
                      input logic [31:0] d);
      int n;
      @(posedge ref_clk);
      psel <= 1'b1;
      pwrite <= w;
      paddr <= a;
      pwdata <= d;
      @(posedge ref_clk);
      penable <= 1'b1;
      for (n = 0; n < 16 && pready !== 1'b1; n++) @(posedge ref_clk);
      if (n >= 16) begin
         n_errors++;
         print_verdict();
      end
      q = prdata;
      e = pslverr;
      psel <= 1'b0;
      penable <= 1'b0;
   endtask
   task automatic settle();
      repeat (4) @(posedge ref_clk);
   endtask
   initial begin
      arst_n = 1'b0;
      {psel, penable, pwrite, paddr, pwdata} = '0;
      {hw_a_out, hw_a_oe, hw_b_out, hw_b_oe, ext_a, ext_b} = '0;
      n_errors = 0;
      samples_checked = 0;
      repeat (6) @(posedge ref_clk);
      arst_n <= 1'b1;
      for (int i = 0; i < 8; i++) begin
         apb(1'b0, offs[i], 32'h0);
         chk("reset value", q, 32'h0);
      end
      hw_a_out <= 18'h2AAAA;
      hw_a_oe <= 18'h3FFFF;
      hw_b_out <= 17'h15555;
      hw_b_oe <= 17'h0F0F0;
      ext_b <= 17'h1FFFF;
      for (int i = 0; i < 8; i++) begin
         apb(1'b1, offs[i], 32'hFFFFFFFF);
         apb(1'b0, offs[i], 32'h0);
         chk("read back", q, msk[i]);
      end
      settle();
      chk("hw A out", port_a_out, 32'h2AAAA);
      chk("hw A oe", port_a_oe, 32'h3FFFF);
      chk("hw B out", port_b_out, 32'h15555);
      chk("hw B oe", port_b_oe, 32'h0F0F0);
      chk("hw B in", hw_b_in, 32'h15F5F);
      chk("irq masked", irq, 32'h0);
      apb(1'b1, tpg_pkg::OFF_IRQ_MASK, 32'h0);
      settle();
      chk("irq unmasked", irq, 32'h1);
      apb(1'b1, tpg_pkg::OFF_IRQ_ENABLE, 32'h0);
      settle();
      chk("irq disabled", irq, 32'h0);
      apb(1'b1, tpg_pkg::OFF_A_SRC, 32'h0);
      apb(1'b1, tpg_pkg::OFF_B_SRC, 32'h0);
      settle();
      chk("sw A out", port_a_out, 32'h3FFFF);
      chk("sw B oe", port_b_oe, 32'h1FFFF);
      apb(1'b1, tpg_pkg::OFF_A_DIR, 32'h15554);
      settle();
      chk("A oe mixed", port_a_oe, 32'h15554);
      apb(1'b1, tpg_pkg::OFF_IRQ_TYPE, 32'h1);
      apb(1'b1, tpg_pkg::OFF_IRQ_CLEAR, 32'h3FFFF);
      apb(1'b1, tpg_pkg::OFF_IRQ_ENABLE, 32'h1);
      settle();
      chk("edge idle", irq, 32'h0);
      ext_a <= 18'h00001;
      @(posedge ref_clk);
      ext_a <= 18'h00000;
      settle();
      chk("edge held", irq, 32'h1);
      apb(1'b0, tpg_pkg::OFF_IRQ_STATUS, 32'h0);
      chk("status", q, 32'h1);
      apb(1'b0, tpg_pkg::OFF_IRQ_RAW, 32'h0);
      chk("raw", q, 32'h15555);
      apb(1'b0, tpg_pkg::OFF_IRQ_TYPE, 32'h0);
      chk("type", q, 32'h1);
      apb(1'b1, tpg_pkg::OFF_A_PINS, 32'h0);
      apb(1'b0, tpg_pkg::OFF_A_PINS, 32'h0);
      chk("A pins", q, 32'h15554);
      apb(1'b0, tpg_pkg::OFF_B_PINS, 32'h0);
      chk("B pins", q, 32'h1FFFF);
      apb(1'b1, tpg_pkg::OFF_IRQ_CLEAR, 32'h1);
      settle();
      chk("edge cleared", irq, 32'h0);
      apb(1'b0, 8'h80, 32'h0);
      chk("unmapped err", e, 32'h1);
      chk("unmapped data", q, 32'h0);
      print_verdict();
   end
endmodule
